// ==== inc/utf_consts.vh ====
`ifndef UTF_CONSTS_VH
`define UTF_CONSTS_VH

// Register offsets on the plain register port
`define UTF_OFS_HOLD     4'h0
`define UTF_OFS_IER      4'h1
`define UTF_OFS_ISR_FCR  4'h2
`define UTF_OFS_LCR      4'h3
`define UTF_OFS_MCR      4'h4
`define UTF_OFS_LSR      4'h5
`define UTF_OFS_EFR      4'h6
`define UTF_OFS_RXTRIG   4'h7
`define UTF_OFS_TXTRIG   4'h8
`define UTF_OFS_HYST     4'h9

// Reset values
`define UTF_RST_IER      8'h00
`define UTF_RST_FCR      8'h00
`define UTF_RST_LCR      8'h03
`define UTF_RST_MCR      8'h00
`define UTF_RST_EFR      8'h00
`define UTF_RST_RXTRIG   8'h08
`define UTF_RST_TXTRIG   8'h08
`define UTF_RST_HYST     8'h04

// Field positions
`define UTF_FCR_FIFO_EN  0
`define UTF_FCR_RX_FLUSH 1
`define UTF_FCR_TX_FLUSH 2
`define UTF_FCR_PROG_TBL 3
`define UTF_FCR_TRIG_LO  4
`define UTF_FCR_TRIG_HI  5
`define UTF_LCR_STOP2    2
`define UTF_LCR_PAR_EN   3
`define UTF_LCR_PAR_EVEN 4
`define UTF_MCR_RTS      1
`define UTF_EFR_ENH      4
`define UTF_EFR_ARTS     6
`define UTF_EFR_ACTS     7
`define UTF_IER_RX       0
`define UTF_IER_TX       1
`define UTF_IER_RTS      6
`define UTF_IER_CTS      7
`define UTF_ISR_NONE     0
`define UTF_ISR_TX       1
`define UTF_ISR_RX       2
`define UTF_ISR_TOUT     3
`define UTF_ISR_FLOW     5

// FIFO geometry
`define UTF_FIFO_DEPTH   8'd128
`define UTF_PTR_W        7
`define UTF_CNT_W        8

// Timing in 16x sampling ticks; the time-out extra is in bit times
`define UTF_TICKS_BIT    4'd15
`define UTF_TICKS_HALF   4'd7
`define UTF_TOUT_EXTRA   10'd12

// Fixed trigger table levels and their hysteresis neighbours
`define UTF_TBL_L0       8'd8
`define UTF_TBL_L1       8'd16
`define UTF_TBL_L2       8'd24
`define UTF_TBL_L3       8'd28
`define UTF_TBL_TOP      8'd32
`define UTF_TBL_BOT      8'd0

`endif

// ==== rtl/utf_core.v ====
// Summary of operation
// - Each serial bit holds the line for sixteen 16x ticks.
// - Frame: start, data LSB first, optional parity, one or two stops.
// - In FIFO mode each holding write pushes into the 128-byte TX FIFO.
// - Non-FIFO: bit 5 sets on move to shifter; bit 6 when holding byte and shifter empty.
// - Non-FIFO: empty holding byte flags source bit 1 if enable bit 1 set.
// - FIFO mode: bit 5 is FIFO empty; bit 6 is FIFO and shifter empty.
// - FIFO mode: TX interrupt when fill is below TX trigger, enable bit 1.
// - After a falling edge, sample at tick eight; high means false start.
// - Bits sampled mid-bit; parity, framing, break go to status bits 2-4.
// - Receive FIFO is 128 entries of data byte plus three error tags.
// - Reading the RX holding byte pops and shows next byte's tags at once.
// - RX interrupt per byte, or at FIFO trigger level; enable bit 0.
// - Data waiting, four characters plus twelve bits idle: time-out.
// - Auto RTS needs both enhanced bit 6 and modem bit 1, in either order, before it runs.
// - Fixed tables: RTS off at next level up, on at next level down.
// - Programmable: RTS follows hysteresis limits; interrupt at trigger.
// - Receiver keeps filling the FIFO after RTS goes high until full.
// - Enable bit 6, locked by enhanced bit 4: RTS off flags source bit 5.
// - Auto CTS with CTS high stops transmit after the current stop bit.
// - Suspended transmitter resumes when CTS returns low.
// - Enable bit 7, locked by enhanced bit 4: CTS high flags source bit 5.
// - Word-length field picks five to eight data bits for both directions.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`include "utf_consts.vh"

module utf_core (
  input  wire       clock_i,
  input  wire       reset_i,
  input  wire [3:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  input  wire       tick16_i,
  input  wire       rx_i,
  output wire       tx_o,
  input  wire       cts_n_i,
  output wire       rts_n_o,
  output wire       irq_o
);

  localparam S_IDLE  = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA  = 3'd2;
  localparam S_PAR   = 3'd3;
  localparam S_STOP  = 3'd4;

  reg  [7:0]  int_enable_reg_q;
  reg  [7:0]  fifo_control_reg_q;
  reg  [7:0]  line_control_reg_q;
  reg  [7:0]  modem_control_reg_q;
  reg  [7:0]  enhanced_feature_reg_q;
  reg  [7:0]  rx_trig_q;
  reg  [7:0]  tx_trig_q;
  reg  [7:0]  hyst_q;
  reg         rx_flush_q;
  reg         tx_flush_q;

  wire        fifo_en  = fifo_control_reg_q[`UTF_FCR_FIFO_EN];
  wire [3:0]  dbits    = 4'd5 + {2'b00, line_control_reg_q[1:0]};
  wire [2:0]  last_bit = dbits[2:0] - 3'd1;
  wire        par_en   = line_control_reg_q[`UTF_LCR_PAR_EN];
  wire        par_even = line_control_reg_q[`UTF_LCR_PAR_EVEN];
  wire [7:0]  limit    = fifo_en ? `UTF_FIFO_DEPTH : 8'd1;

  wire        wr_hold  = wr_i && (addr_i == `UTF_OFS_HOLD);
  wire        rd_hold  = rd_i && (addr_i == `UTF_OFS_HOLD);
  wire        rd_isr   = rd_i && (addr_i == `UTF_OFS_ISR_FCR);

  // Transmit FIFO; one entry is usable in non-FIFO mode
  wire [7:0]  tx_head;
  wire [7:0]  tx_count;
  wire        tx_pop;
  wire        tx_push = wr_hold && (tx_count < limit);

  utf_fifo #(.WIDTH(8)) u_tx_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .flush_i     (tx_flush_q),
    .push_i      (tx_push),
    .push_data_i (wdata_i),
    .pop_i       (tx_pop),
    .head_o      (tx_head),
    .count_o     (tx_count)
  );

  // Receive FIFO of data plus break, framing and parity tags
  wire [10:0] rx_head;
  wire [7:0]  rx_count;
  reg         rx_push;
  reg  [10:0] rx_word;

  utf_fifo #(.WIDTH(11)) u_rx_fifo (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .flush_i     (rx_flush_q),
    .push_i      (rx_push),
    .push_data_i (rx_word),
    .pop_i       (rd_hold),
    .head_o      (rx_head),
    .count_o     (rx_count)
  );

  // Empty FIFO shows zero, never a stale or unwritten head entry
  wire        rx_ready = (rx_count != 8'd0);
  wire [10:0] rx_shown = rx_ready ? rx_head : 11'h000;

  // Transmitter
  reg  [2:0]  tx_state_q;
  reg  [3:0]  tx_tick_q;
  reg  [2:0]  tx_bit_q;
  reg  [7:0]  tx_shift_register_q;
  reg         tx_par_q;
  reg         tx_line_q;
  wire        auto_cts  = enhanced_feature_reg_q[`UTF_EFR_ACTS];
  wire        cts_hold  = auto_cts && cts_n_i;
  wire        tx_idle   = (tx_state_q == S_IDLE);
  wire        tx_bitend = tick16_i && (tx_tick_q == `UTF_TICKS_BIT);
  wire [7:0]  tx_mask   = 8'hff >> (4'd8 - dbits);
  wire        tx_ones   = ^(tx_head & tx_mask);

  // A new character starts only between characters, so CTS never cuts one
  assign tx_pop = tx_idle && (tx_count != 8'd0) && !cts_hold;
  assign tx_o   = tx_line_q;

  always @(posedge clock_i) begin
    if (reset_i) begin
      tx_state_q          <= S_IDLE;
      tx_tick_q           <= 4'h0;
      tx_bit_q            <= 3'h0;
      tx_shift_register_q <= 8'h00;
      tx_par_q            <= 1'b0;
      tx_line_q           <= 1'b1;
    end else if (tx_pop) begin
      tx_state_q          <= S_START;
      tx_tick_q           <= 4'h0;
      tx_bit_q            <= 3'h0;
      tx_shift_register_q <= tx_head;
      tx_par_q            <= par_even ? tx_ones : ~tx_ones;
      tx_line_q           <= 1'b0;
    end else if (!tx_idle && tick16_i) begin
      tx_tick_q <= tx_tick_q + 4'h1;
      if (tx_bitend) begin
        case (tx_state_q)
          S_START: begin
            tx_state_q <= S_DATA;
            tx_line_q  <= tx_shift_register_q[0];
          end
          S_DATA: begin
            if (tx_bit_q == last_bit) begin
              tx_bit_q   <= 3'h0;
              tx_state_q <= par_en ? S_PAR : S_STOP;
              tx_line_q  <= par_en ? tx_par_q : 1'b1;
            end else begin
              tx_bit_q            <= tx_bit_q + 3'h1;
              tx_shift_register_q <= {1'b0, tx_shift_register_q[7:1]};
              tx_line_q           <= tx_shift_register_q[1];
            end
          end
          S_PAR: begin
            tx_state_q <= S_STOP;
            tx_line_q  <= 1'b1;
          end
          S_STOP: begin
            if (line_control_reg_q[`UTF_LCR_STOP2] && tx_bit_q == 3'h0) begin
              tx_bit_q <= 3'h1;
            end else begin
              tx_state_q <= S_IDLE;
            end
          end
          default: tx_state_q <= S_IDLE;
        endcase
      end
    end
  end

  // Receiver
  reg  [2:0]  rx_state_q;
  reg  [3:0]  rx_tick_q;
  reg  [2:0]  rx_bit_q;
  reg  [7:0]  rx_shift_register_q;
  reg         rx_par_q;
  reg         rx_any1_q;
  reg         rx_prev_q;
  wire        rx_fall   = tick16_i && rx_prev_q && !rx_i;
  wire        rx_mid    = tick16_i && (rx_tick_q == `UTF_TICKS_BIT);
  wire        rx_half   = tick16_i && (rx_tick_q == `UTF_TICKS_HALF);
  wire [7:0]  rx_align  = {rx_i, rx_shift_register_q[7:1]} >> (4'd8 - dbits);
  wire [7:0]  rx_stored = rx_shift_register_q >> (4'd8 - dbits);
  wire        rx_perr   = par_en && (par_even ? rx_par_q : ~rx_par_q);

  always @(posedge clock_i) begin
    if (reset_i) begin
      rx_state_q          <= S_IDLE;
      rx_tick_q           <= 4'h0;
      rx_bit_q            <= 3'h0;
      rx_shift_register_q <= 8'h00;
      rx_par_q            <= 1'b0;
      rx_any1_q           <= 1'b0;
      rx_prev_q           <= 1'b1;
      rx_push             <= 1'b0;
      rx_word             <= 11'h000;
    end else begin
      rx_push <= 1'b0;
      if (tick16_i) begin
        rx_prev_q <= rx_i;
        rx_tick_q <= rx_tick_q + 4'h1;
      end
      case (rx_state_q)
        S_IDLE: begin
          if (rx_fall) begin
            rx_state_q <= S_START;
            rx_tick_q  <= 4'h0;
          end
        end
        S_START: begin
          if (rx_half) begin
            rx_tick_q  <= 4'h0;
            rx_bit_q   <= 3'h0;
            rx_par_q   <= 1'b0;
            rx_any1_q  <= 1'b0;
            // A high line here was a glitch: drop it silently
            rx_state_q <= rx_i ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_mid) begin
            rx_shift_register_q <= {rx_i, rx_shift_register_q[7:1]};
            rx_par_q  <= rx_par_q ^ rx_i;
            rx_any1_q <= rx_any1_q | rx_i;
            if (rx_bit_q == last_bit) begin
              rx_shift_register_q <= rx_align;
              rx_state_q <= par_en ? S_PAR : S_STOP;
            end else begin
              rx_bit_q <= rx_bit_q + 3'h1;
            end
          end
        end
        S_PAR: begin
          if (rx_mid) begin
            rx_par_q   <= rx_par_q ^ rx_i;
            rx_any1_q  <= rx_any1_q | rx_i;
            rx_state_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (rx_mid) begin
            rx_state_q <= S_IDLE;
            // Keeps filling past the RTS point; only a full FIFO drops data
            rx_push    <= (rx_count < limit);
            rx_word    <= {!rx_i && !rx_any1_q, !rx_i, rx_perr,
                           rx_shift_register_q};
          end
        end
        default: rx_state_q <= S_IDLE;
      endcase
    end
  end

  // Receive time-out: four characters of data bits plus twelve bits
  reg  [9:0]  tout_cnt_q;
  reg         tout_flag_q;
  // At most 44 bits, so six bits of the sum are enough before times sixteen
  wire [9:0]  tout_bits = {4'h0, dbits, 2'b00} + `UTF_TOUT_EXTRA;
  wire [9:0]  tout_lim  = {tout_bits[5:0], 4'h0};

  always @(posedge clock_i) begin
    if (reset_i) begin
      tout_cnt_q  <= 10'h000;
      tout_flag_q <= 1'b0;
    end else if (rx_push || rd_hold || rx_count == 8'd0) begin
      tout_cnt_q  <= 10'h000;
      tout_flag_q <= 1'b0;
    end else if (tick16_i && !tout_flag_q) begin
      tout_cnt_q <= tout_cnt_q + 10'h001;
      if (tout_cnt_q == tout_lim - 10'h001) begin
        tout_flag_q <= 1'b1;
      end
    end
  end

  // Auto RTS levels
  reg  [7:0]  rts_hi;
  reg  [7:0]  rts_lo;
  reg  [7:0]  rx_level;

  // Fixed table uses its neighbours; programmable table uses hysteresis
  always @* begin
    rx_level = rx_trig_q;
    rts_hi   = rx_trig_q + hyst_q;
    rts_lo   = (rx_trig_q > hyst_q) ? rx_trig_q - hyst_q : 8'h00;
    if (!fifo_control_reg_q[`UTF_FCR_PROG_TBL]) begin
      case (fifo_control_reg_q[`UTF_FCR_TRIG_HI:`UTF_FCR_TRIG_LO])
        2'd0: begin
          rx_level = `UTF_TBL_L0;
          rts_hi   = `UTF_TBL_L1;
          rts_lo   = `UTF_TBL_BOT;
        end
        2'd1: begin
          rx_level = `UTF_TBL_L1;
          rts_hi   = `UTF_TBL_L2;
          rts_lo   = `UTF_TBL_L0;
        end
        2'd2: begin
          rx_level = `UTF_TBL_L2;
          rts_hi   = `UTF_TBL_L3;
          rts_lo   = `UTF_TBL_L1;
        end
        default: begin
          rx_level = `UTF_TBL_L3;
          rts_hi   = `UTF_TBL_TOP;
          rts_lo   = `UTF_TBL_L2;
        end
      endcase
    end
  end

  reg         rts_off_q;
  reg         cts_prev_q;
  reg         flow_ev_q;
  wire        auto_rts = enhanced_feature_reg_q[`UTF_EFR_ARTS] &&
                         modem_control_reg_q[`UTF_MCR_RTS];
  wire        rts_set  = auto_rts && !rts_off_q && (rx_count >= rts_hi);
  wire        cts_rise = auto_cts && cts_n_i && !cts_prev_q;
  wire        rts_irq  = rts_set && int_enable_reg_q[`UTF_IER_RTS];
  wire        cts_irq  = cts_rise && int_enable_reg_q[`UTF_IER_CTS];
  wire        flow_set = rts_irq || cts_irq;

  // RTS flag plus a sticky flow event that an INT_SOURCE_REG read clears; a new event in that cycle wins
  always @(posedge clock_i) begin
    if (reset_i) begin
      rts_off_q  <= 1'b0;
      cts_prev_q <= 1'b0;
      flow_ev_q  <= 1'b0;
    end else begin
      cts_prev_q <= cts_n_i;
      if (!auto_rts) begin
        rts_off_q <= 1'b0;
      end else if (rts_set) begin
        rts_off_q <= 1'b1;
      end else if (rx_count <= rts_lo) begin
        rts_off_q <= 1'b0;
      end
      if (flow_set) begin
        flow_ev_q <= 1'b1;
      end else if (rd_isr) begin
        flow_ev_q <= 1'b0;
      end
    end
  end

  // Remote sender is trusted to honour this line within one character;
  // gating by the arm bit frees the pin at once when auto RTS is dropped
  assign rts_n_o = !modem_control_reg_q[`UTF_MCR_RTS] ||
                   (auto_rts && rts_off_q);

  // Status and interrupt source
  wire        tx_hold_empty = (tx_count == 8'd0);
  wire        tx_all_empty  = tx_hold_empty && tx_idle;
  wire        tx_int_cond   = fifo_en ? (tx_count < tx_trig_q)
                                      : tx_hold_empty;
  wire        rx_int_cond   = fifo_en ? (rx_count >= rx_level)
                                      : (rx_count != 8'd0);
  wire        tx_int = tx_int_cond && int_enable_reg_q[`UTF_IER_TX];
  wire        rx_int = rx_int_cond && int_enable_reg_q[`UTF_IER_RX];
  wire        to_int = tout_flag_q && int_enable_reg_q[`UTF_IER_RX];
  wire [7:0]  line_status_reg = {1'b0, tx_all_empty, tx_hold_empty,
                                 rx_shown[10:8], 1'b0,
                                 rx_ready};
  wire [7:0]  int_source_reg  = {2'b00, flow_ev_q, 1'b0, to_int, rx_int,
                                 tx_int, !(tx_int | rx_int | to_int |
                                 flow_ev_q)};

  assign irq_o = !int_source_reg[`UTF_ISR_NONE];

  // Register writes; enables 6 and 7 are locked until enhanced bit 4
  always @(posedge clock_i) begin
    if (reset_i) begin
      int_enable_reg_q       <= `UTF_RST_IER;
      fifo_control_reg_q     <= `UTF_RST_FCR;
      line_control_reg_q     <= `UTF_RST_LCR;
      modem_control_reg_q    <= `UTF_RST_MCR;
      enhanced_feature_reg_q <= `UTF_RST_EFR;
      rx_trig_q              <= `UTF_RST_RXTRIG;
      tx_trig_q              <= `UTF_RST_TXTRIG;
      hyst_q                 <= `UTF_RST_HYST;
      rx_flush_q             <= 1'b0;
      tx_flush_q             <= 1'b0;
    end else begin
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
      if (wr_i) begin
        case (addr_i)
          `UTF_OFS_IER: begin
            int_enable_reg_q <= enhanced_feature_reg_q[`UTF_EFR_ENH] ?
                                wdata_i : {2'b00, wdata_i[5:0]};
          end
          `UTF_OFS_ISR_FCR: begin
            fifo_control_reg_q <= wdata_i;
            rx_flush_q <= wdata_i[`UTF_FCR_RX_FLUSH] ||
                          (wdata_i[0] != fifo_en);
            tx_flush_q <= wdata_i[`UTF_FCR_TX_FLUSH] ||
                          (wdata_i[0] != fifo_en);
          end
          `UTF_OFS_LCR:    line_control_reg_q     <= wdata_i;
          `UTF_OFS_MCR:    modem_control_reg_q    <= wdata_i;
          `UTF_OFS_EFR:    enhanced_feature_reg_q <= wdata_i;
          `UTF_OFS_RXTRIG: rx_trig_q              <= wdata_i;
          `UTF_OFS_TXTRIG: tx_trig_q              <= wdata_i;
          `UTF_OFS_HYST:   hyst_q                 <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  // Read data stands for the one cycle after the strobe
  always @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `UTF_OFS_HOLD:    rdata_o <= rx_shown[7:0];
        `UTF_OFS_IER:     rdata_o <= int_enable_reg_q;
        `UTF_OFS_ISR_FCR: rdata_o <= int_source_reg;
        `UTF_OFS_LCR:     rdata_o <= line_control_reg_q;
        `UTF_OFS_MCR:     rdata_o <= modem_control_reg_q;
        `UTF_OFS_LSR:     rdata_o <= line_status_reg;
        `UTF_OFS_EFR:     rdata_o <= enhanced_feature_reg_q;
        `UTF_OFS_RXTRIG:  rdata_o <= rx_trig_q;
        `UTF_OFS_TXTRIG:  rdata_o <= tx_trig_q;
        `UTF_OFS_HYST:    rdata_o <= hyst_q;
        default:          rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule

// ==== rtl/utf_fifo.v ====
`timescale 1ns/10ps
`include "utf_consts.vh"

module utf_fifo #(
  parameter WIDTH = 8
) (
  input  wire                  clock_i,
  input  wire                  reset_i,
  input  wire                  flush_i,
  input  wire                  push_i,
  input  wire [WIDTH-1:0]      push_data_i,
  input  wire                  pop_i,
  output wire [WIDTH-1:0]      head_o,
  output wire [`UTF_CNT_W-1:0] count_o
);

  reg [WIDTH-1:0]      mem_q [0:127];
  reg [`UTF_PTR_W-1:0] wr_ptr_q;
  reg [`UTF_PTR_W-1:0] rd_ptr_q;
  reg [`UTF_CNT_W-1:0] count_q;
  wire                 push_ok;
  wire                 pop_ok;

  // Overflowing pushes and underflowing pops are dropped here
  assign push_ok = push_i && (count_q != `UTF_FIFO_DEPTH);
  assign pop_ok  = pop_i && (count_q != 8'd0);
  assign head_o  = mem_q[rd_ptr_q];
  assign count_o = count_q;

  // Storage has no reset; only pointers define what is valid
  always @(posedge clock_i) begin
    if (push_ok) begin
      mem_q[wr_ptr_q] <= push_data_i;
    end
  end

  // Pointers wrap naturally at 128 entries
  always @(posedge clock_i) begin
    if (reset_i || flush_i) begin
      wr_ptr_q <= 7'h00;
      rd_ptr_q <= 7'h00;
      count_q  <= 8'h00;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + 7'h01;
      end
      if (pop_ok) begin
        rd_ptr_q <= rd_ptr_q + 7'h01;
      end
      case ({push_ok, pop_ok})
        2'b10:   count_q <= count_q + 8'h01;
        2'b01:   count_q <= count_q - 8'h01;
        default: count_q <= count_q;
      endcase
    end
  end

endmodule

// ==== verification/utf_core_chk.sv ====
`timescale 1ns/10ps
module utf_core_chk (
  input wire       clock_i,
  input wire       reset_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  input wire       tick16_i,
  input wire       rx_i,
  input wire       tx_o,
  input wire       cts_n_i,
  input wire       rts_n_o,
  input wire       irq_o
);
  logic [7:0] ier_q;
  logic [7:0] efr_q;
  logic [7:0] mcr_q;
  logic [7:0] hi_q;
  logic [4:0] lo_q;
  // Shadow controls; tick counts of the present low and high runs on TX
  always @(posedge clock_i) begin
    if (reset_i) begin
      ier_q <= 8'h00;
      efr_q <= 8'h00;
      mcr_q <= 8'h00;
      lo_q  <= 5'h00;
      hi_q  <= 8'h00;
    end else begin
      if (wr_i && addr_i == 4'h1) ier_q <= wdata_i;
      if (wr_i && addr_i == 4'h6) efr_q <= wdata_i;
      if (wr_i && addr_i == 4'h4) mcr_q <= wdata_i;
      if (tx_o) lo_q <= 5'h00;
      else if (tick16_i && lo_q != 5'h1f) lo_q <= lo_q + 5'h01;
      if (!tx_o) hi_q <= 8'h00;
      else if (tick16_i && hi_q != 8'hff) hi_q <= hi_q + 8'h01;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence unmapped_rd_s;
    rd_i && addr_i > 4'h9;
  endsequence
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("stray read data");
  unmapped_rd_a: assert property (unmapped_rd_s |=> rdata_o == 8'h00)
    else $error("unmapped read data");
  reset_idle_a: assert property (
    $fell(reset_i) |-> tx_o && rts_n_o && !irq_o) else $error("reset idle");
  bit_len_a: assert property ($rose(tx_o) |-> lo_q >= 5'd16)
    else $error("low bit too short");
  rise_tick_a: assert property ($rose(tx_o) |-> $past(tick16_i))
    else $error("tx edge off tick");
  cts_hold_a: assert property (
    efr_q[7] && cts_n_i && $past(cts_n_i) && hi_q == 8'hff |=> tx_o)
    else $error("start while cts high");
  rts_manual_a: assert property (
    !efr_q[6] |-> rts_n_o == !mcr_q[1]) else $error("rts not manual");
  irq_quiet_a: assert property (
    ier_q == 8'h00 |-> !irq_o) else $error("irq with no enables");
endmodule
bind utf_core utf_core_chk u_chk (.clock_i(clock_i), .reset_i(reset_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .tick16_i(tick16_i), .rx_i(rx_i), .tx_o(tx_o),
  .cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .irq_o(irq_o));

// ==== verification/utf_core_tb_top.sv ====
`timescale 1ns/10ps
module utf_core_tb_top;
  logic clock_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic tick16_i = 1'b0, hold = 1'b0;
  logic [3:0] addr_i = 4'h0, nbits = 4'd8;
  logic [7:0] wdata_i = 8'h00;
  logic [1:0] tdiv_q = 2'd0;
  wire  [7:0] rdata_o;
  wire        rx_w, tx_w, cts_n_w, rts_n_w, irq_o;
  int num_errors = 0, samples_checked = 0, k;
  logic [3:0] ofs [9] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'h5, 4'hf};
  logic [7:0] rv [9] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h08, 8'h08, 8'h04,
                         8'h60, 8'h00};
  utf_core DUT (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tick16_i(tick16_i), .rx_i(rx_w), .tx_o(tx_w), .cts_n_i(cts_n_w),
    .rts_n_o(rts_n_w), .irq_o(irq_o));
  utf_remote REM (.clock_i(clock_i), .tick16_i(tick16_i), .line_i(tx_w),
    .rts_n_i(rts_n_w), .nbits_i(nbits), .hold_i(hold), .line_o(rx_w),
    .cts_n_o(cts_n_w));
  always #10 clock_i = ~clock_i;
  // Sampling enable every fourth clock keeps frames short
  always @(posedge clock_i) begin
    tdiv_q <= tdiv_q + 2'd1;
    tick16_i <= (tdiv_q == 2'd3);
  end
  task wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(posedge clock_i);
    d = rdata_o;
  endtask
  task check(input string n, input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    check(n, d, e);
  endtask
  task wait_got(input int n);
    repeat (20000) if (REM.got.size() < n) @(posedge clock_i);
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, well past the twelve thousand or so cycles the tests need
  initial begin
    #1000000;
    num_errors++;
    conclude;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    for (k = 0; k < 9; k++) rdchk(ofs[k], rv[k], "reset value");
    $display("test reset values done");
    wr(4'h4, 8'h02);
    wr(4'h0, 8'ha5);
    wait_got(1);
    repeat (40) @(posedge clock_i);
    check("tx byte", REM.got[0], 8'ha5);
    rdchk(4'h5, 8'h60, "tx empty flags");
    wr(4'h1, 8'h02);
    check("tx irq", {7'h00, irq_o}, 8'h01);
    rdchk(4'h2, 8'h02, "tx source");
    $display("test holding transmit done");
    wr(4'h3, 8'h00);
    nbits = 4'd5;
    wr(4'h1, 8'h01);
    REM.send(8'h15);
    repeat (4) @(posedge clock_i);
    check("rx irq", {7'h00, irq_o}, 8'h01);
    rdchk(4'h0, 8'h15, "rx byte");
    rdchk(4'h5, 8'h60, "rx drained");
    wr(4'h0, 8'h3a);
    wait_got(2);
    check("short tx", REM.got[1], 8'h1a);
    repeat (40) @(posedge clock_i);
    REM.glitch;
    rdchk(4'h5, 8'h60, "false start");
    $display("test short words done");
    wr(4'h3, 8'h03);
    nbits = 4'd8;
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h01);
    for (k = 0; k < 3; k++) wr(4'h0, 8'h10 + k[7:0]);
    wait_got(5);
    for (k = 0; k < 3; k++) begin
      check("fifo tx", REM.got[2+k], 8'h10 + k[7:0]);
    end
    REM.send(8'hc3);
    REM.send(8'h3c);
    repeat (4) @(posedge clock_i);
    rdchk(4'h0, 8'hc3, "fifo rx 1");
    rdchk(4'h0, 8'h3c, "fifo rx 2");
    $display("test fifo mode done");
    // One byte below trigger; 44 bits of 16 ticks of 4 clocks is 2816
    wr(4'h1, 8'h01);
    REM.send(8'h77);
    repeat (2700) @(posedge clock_i);
    rdchk(4'h2, 8'h01, "no tout yet");
    repeat (200) @(posedge clock_i);
    rdchk(4'h2, 8'h08, "rx tout");
    rdchk(4'h0, 8'h77, "tout byte");
    $display("test rx timeout done");
    wr(4'h6, 8'h80);
    hold <= 1'b1;
    repeat (4) @(posedge clock_i);
    wr(4'h0, 8'h5a);
    repeat (1500) @(posedge clock_i);
    check("cts pause", 8'(REM.got.size()), 8'd5);
    hold <= 1'b0;
    wait_got(6);
    check("cts resume", REM.got[5], 8'h5a);
    $display("test auto cts done");
    // Programmable table, trigger 1 and hysteresis 1: off at 2, on at 0
    wr(4'h7, 8'h01);
    wr(4'h9, 8'h01);
    wr(4'h2, 8'h09);
    wr(4'h6, 8'h40);
    wr(4'h4, 8'h02);
    REM.send(8'h01);
    REM.send(8'h02);
    repeat (4) @(posedge clock_i);
    check("rts off", {7'h00, rts_n_w}, 8'h01);
    rdchk(4'h0, 8'h01, "rts rx 1");
    rdchk(4'h0, 8'h02, "rts rx 2");
    @(posedge clock_i);
    check("rts on", {7'h00, rts_n_w}, 8'h00);
    $display("test auto rts done");
    conclude;
  end
endmodule

// ==== verification/utf_remote.sv ====
`timescale 1ns/10ps
module utf_remote (
  input  wire       clock_i,
  input  wire       tick16_i,
  input  wire       line_i,
  input  wire       rts_n_i,
  input  wire [3:0] nbits_i,
  input  wire       hold_i,
  output reg        line_o,
  output wire       cts_n_o
);
  logic [7:0] got [$];
  // Our pause request goes straight to the block's clear-to-send
  assign cts_n_o = hold_i;
  initial line_o = 1'b1;
  task automatic ticks(input int n);
    repeat (n) begin
      do @(posedge clock_i); while (tick16_i !== 1'b1);
    end
  endtask
  // Whole frames only, and none started while the block says stop
  task automatic send(input logic [7:0] b);
    int i;
    while (rts_n_i !== 1'b0) @(posedge clock_i);
    ticks(1);
    line_o <= 1'b0;
    ticks(16);
    for (i = 0; i < nbits_i; i++) begin
      line_o <= b[i];
      ticks(16);
    end
    line_o <= 1'b1;
    ticks(16);
  endtask
  // Short low pulse that must not pass for a start bit
  task automatic glitch;
    ticks(1);
    line_o <= 1'b0;
    ticks(4);
    line_o <= 1'b1;
    ticks(32);
  endtask
  // Receiver samples mid-bit, LSB first
  initial begin : rx_loop
    logic [7:0] b;
    int i;
    forever begin
      @(negedge line_i);
      ticks(8);
      if (line_i === 1'b0) begin
        b = 8'h00;
        for (i = 0; i < nbits_i; i++) begin
          ticks(16);
          b[i] = line_i;
        end
        ticks(16);
        got.push_back(b);
      end
    end
  end
endmodule
